//--- inc/mab_consts.vh
`ifndef MAB_CONSTS_VH
`define MAB_CONSTS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define MAB_ADDR_CTRL 4'h0
`define MAB_ADDR_STATUS 4'h4

// ****************************************
// control register fields
// ****************************************
`define MAB_CTRL_W 6
`define MAB_CTRL_IN_REG 0
`define MAB_CTRL_PIPE_REG 1
`define MAB_CTRL_OUT_REG 2
`define MAB_CTRL_WIDE 3
`define MAB_CTRL_NINE_LOW 4
`define MAB_CTRL_NINE_HIGH 5
`define MAB_CTRL_RST 6'h07

// ****************************************
// status register fields
// ****************************************
`define MAB_STAT_W 2

// ****************************************
// half modes
// ****************************************
`define MAB_MODE_SIMPLE 2'h0
`define MAB_MODE_ACCUM 2'h1
`define MAB_MODE_ADD2 2'h2
`define MAB_MODE_ADD4 2'h3

// ****************************************
// fixed-point constants (q1.15 operands)
// ****************************************
`define MAB_PROD_RND_INC 36'h000004000
`define MAB_PROD_RND_MASK 36'h000007fff
`define MAB_PROD_QMAX 36'h03fffffff
`define MAB_PROD_QMIN 36'hfc0000000
`define MAB_SUM_RND_INC 53'h00000000004000
`define MAB_SUM_RND_MASK 53'h00000000007fff
`define MAB_ACC_MAX 52'h7ffffffffffff
`define MAB_ACC_MIN 52'h8000000000000

`endif

//--- hw/mab_unit.v
`timescale 1ns/1ps
`include "mab_consts.vh"

// one 18x18 unit: input registers, multiplier, product round/saturate, pipeline
module mab_unit (
  input wire clk,
  input wire in_clr,         // async clear of input registers
  input wire in_ena,         // capture enable of input registers
  input wire pipe_clr,       // async clear of pipeline register
  input wire pipe_ena,       // capture enable of pipeline register
  input wire in_reg_on,      // 0: input registers bypassed
  input wire pipe_on,        // 0: pipeline register bypassed
  input wire shift_a,        // load a from the chain
  input wire shift_b,        // load b from the chain
  input wire [17:0] a_par,
  input wire [17:0] b_par,
  input wire [17:0] a_chain,
  input wire [17:0] b_chain,
  input wire sign_a,
  input wire sign_b,
  input wire nine,           // split into two 9x9 products
  input wire rnd,
  input wire sat,
  output reg [17:0] a_ff,    // input registers, also chain outputs
  output reg [17:0] b_ff,
  output wire [35:0] prod
);

  // ****************************************
  // input register stage
  // ****************************************
  // parallel or shift loading, held while enable is low
  always @(posedge clk or posedge in_clr) begin
    if (in_clr) begin
      a_ff <= 18'h00000;
      b_ff <= 18'h00000;
    end else if (in_ena) begin
      a_ff <= shift_a ? a_chain : a_par;
      b_ff <= shift_b ? b_chain : b_par;
    end
  end

  wire [17:0] a_use = in_reg_on ? a_ff : a_par;
  wire [17:0] b_use = in_reg_on ? b_ff : b_par;

  // ****************************************
  // multiplier stage
  // ****************************************
  // one extra bit carries the sign choice of each operand
  wire signed [18:0] ax = {sign_a & a_use[17], a_use};
  wire signed [18:0] bx = {sign_b & b_use[17], b_use};
  wire signed [37:0] p18 = ax * bx;
  wire signed [9:0] ahx = {sign_a & a_use[17], a_use[17:9]};
  wire signed [9:0] bhx = {sign_b & b_use[17], b_use[17:9]};
  wire signed [9:0] alx = {sign_a & a_use[8], a_use[8:0]};
  wire signed [9:0] blx = {sign_b & b_use[8], b_use[8:0]};
  wire signed [19:0] phi = ahx * bhx;
  wire signed [19:0] plo = alx * blx;
  wire [35:0] p9 = {phi[17:0], plo[17:0]};

  // q1.15 rounding at bit 14 then saturation to q1.30 range
  wire [35:0] p_rnd = rnd ? ((p18[35:0] + `MAB_PROD_RND_INC) & ~`MAB_PROD_RND_MASK)
                          : p18[35:0];
  wire signed [35:0] p_rs = p_rnd;
  reg [35:0] p_fix;

  // saturation only for 18x18 products
  always @* begin
    p_fix = p_rnd;
    if (sat && p_rs > $signed(`MAB_PROD_QMAX)) begin
      p_fix = `MAB_PROD_QMAX;
    end else if (sat && p_rs < $signed(`MAB_PROD_QMIN)) begin
      p_fix = `MAB_PROD_QMIN;
    end
  end

  wire [35:0] p_comb = nine ? p9 : p_fix;

  // ****************************************
  // pipeline register stage
  // ****************************************
  reg [35:0] pipe_ff;

  always @(posedge clk or posedge pipe_clr) begin
    if (pipe_clr) begin
      pipe_ff <= 36'h000000000;
    end else if (pipe_ena) begin
      pipe_ff <= p_comb;
    end
  end

  assign prod = pipe_on ? pipe_ff : p_comb;

endmodule // mab_unit

//--- hw/mab_top.v
`timescale 1ns/1ps
`include "mab_consts.vh"

module mab_top (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // control bus from user logic, one set per index
  input wire [3:0] ASYNC_CLEAR,
  input wire [3:0] STAGE_CLOCK_ENABLE,
  input wire SIGN_A,
  input wire SIGN_B,
  input wire PAIR_LOW_PRODUCT_SATURATE,
  input wire PAIR_LOW_PRODUCT_ROUND,
  input wire PAIR_HIGH_PRODUCT_SATURATE,
  input wire PAIR_HIGH_PRODUCT_ROUND,
  input wire LOW_HALF_ADD_SUBTRACT_SELECT,
  input wire HIGH_HALF_ADD_SUBTRACT_SELECT,
  input wire [1:0] LOW_HALF_MODE_SELECT,
  input wire [1:0] HIGH_HALF_MODE_SELECT,
  input wire [1:0] ACCUM_ROUND,
  input wire [1:0] ACCUM_SATURATE,
  input wire [1:0] ACCUM_LOAD,
  input wire [3:0] SHIFT_SELECT_A,
  input wire [3:0] SHIFT_SELECT_B,
  // operand buses 18 bits per unit, result bus 36 bits per unit
  input wire [71:0] OPERAND_A,
  input wire [71:0] OPERAND_B,
  output wire [143:0] RESULT,
  // shift chain to and from neighbouring blocks
  input wire [17:0] SHIFT_IN_A,
  input wire [17:0] SHIFT_IN_B,
  output wire [17:0] SHIFT_OUT_A,
  output wire [17:0] SHIFT_OUT_B,
  // avalon-mm slave
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST
);

  // ****************************************
  // configuration and bus slave
  // ****************************************
  reg [`MAB_CTRL_W-1:0] ctrl_ff;    // stage bypasses and sizes
  reg [`MAB_STAT_W-1:0] sat_flag_ff; // sticky accumulator saturation
  wire [1:0] sat_set;                // saturation events per half

  wire bus_req = AVS_READ | AVS_WRITE;
  wire bus_go = bus_req & ~AVS_WAITREQUEST; // the edge that completes
  wire wr_ctrl = bus_go & AVS_WRITE & (AVS_ADDRESS == `MAB_ADDR_CTRL);
  wire wr_stat = bus_go & AVS_WRITE & (AVS_ADDRESS == `MAB_ADDR_STATUS);
  reg [31:0] rd_mux;

  // read decode, unmapped addresses read zero
  always @* begin
    if (AVS_ADDRESS == `MAB_ADDR_CTRL) begin
      rd_mux = {26'h0000000, ctrl_ff};
    end else if (AVS_ADDRESS == `MAB_ADDR_STATUS) begin
      rd_mux = {30'h00000000, sat_flag_ff};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // one wait cycle per access: read data load on the same edge that drops waitrequest
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      ctrl_ff <= `MAB_CTRL_RST;
    end else begin
      if (bus_req && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        if (AVS_READ) begin
          AVS_READDATA <= rd_mux;
        end
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
      // only lane 0 holds control bits
      if (wr_ctrl && AVS_BYTEENABLE[0]) begin
        ctrl_ff <= AVS_WRITEDATA[`MAB_CTRL_W-1:0];
      end
    end
  end

  // write one to clear; a new event in the same cycle wins
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sat_flag_ff <= 2'h0;
    end else if (wr_stat && AVS_BYTEENABLE[0]) begin
      sat_flag_ff <= (sat_flag_ff & ~AVS_WRITEDATA[1:0]) | sat_set;
    end else begin
      sat_flag_ff <= sat_flag_ff | sat_set;
    end
  end

  wire in_on = ctrl_ff[`MAB_CTRL_IN_REG];
  wire pipe_on = ctrl_ff[`MAB_CTRL_PIPE_REG];
  wire out_on = ctrl_ff[`MAB_CTRL_OUT_REG];
  wire wide = ctrl_ff[`MAB_CTRL_WIDE];

  // ****************************************
  // control bus fan-out
  // ****************************************
  wire [3:0] clr_set = ASYNC_CLEAR | {4{RST}};
  wire [1:0] pair_rnd = {PAIR_HIGH_PRODUCT_ROUND, PAIR_LOW_PRODUCT_ROUND};
  wire [1:0] pair_sat = {PAIR_HIGH_PRODUCT_SATURATE, PAIR_LOW_PRODUCT_SATURATE};
  wire [1:0] add_sel = {HIGH_HALF_ADD_SUBTRACT_SELECT, LOW_HALF_ADD_SUBTRACT_SELECT};
  wire [3:0] mode_sel = {HIGH_HALF_MODE_SELECT, LOW_HALF_MODE_SELECT};
  wire [1:0] nine_sel = {ctrl_ff[`MAB_CTRL_NINE_HIGH], ctrl_ff[`MAB_CTRL_NINE_LOW]} & ~{2{wide}};
  wire ext = SIGN_A | SIGN_B; // products carry a sign when any operand does

  // ****************************************
  // four multiplier units
  // ****************************************
  wire [143:0] prod;  // unit products, 36 bits each
  wire [71:0] a_reg;  // input registers, chain sources
  wire [71:0] b_reg;

  genvar u;
  generate
    for (u = 0; u < 4; u = u + 1) begin : g_unit
      // in 36x36 mode units form the four cross products of a 36-bit pair
      localparam WA = u % 2;
      localparam WB = u / 2;
      wire [17:0] a_in = wide ? OPERAND_A[WA*18 +: 18] : OPERAND_A[u*18 +: 18];
      wire [17:0] b_in = wide ? OPERAND_B[WB*18 +: 18] : OPERAND_B[u*18 +: 18];
      wire sa = wide ? (SIGN_A & (WA == 1)) : SIGN_A;
      wire sb = wide ? (SIGN_B & (WB == 1)) : SIGN_B;
      wire [17:0] a_ch;
      wire [17:0] b_ch;
      if (u == 0) begin : g_head
        assign a_ch = SHIFT_IN_A;
        assign b_ch = SHIFT_IN_B;
      end else begin : g_link
        assign a_ch = a_reg[(u-1)*18 +: 18];
        assign b_ch = b_reg[(u-1)*18 +: 18];
      end
      mab_unit u_unit (
        .clk(REF_CLK),
        .in_clr(clr_set[u]),
        .in_ena(STAGE_CLOCK_ENABLE[u]),
        .pipe_clr(clr_set[u]),
        .pipe_ena(STAGE_CLOCK_ENABLE[u]),
        .in_reg_on(in_on),
        .pipe_on(pipe_on),
        .shift_a(SHIFT_SELECT_A[u]),
        .shift_b(SHIFT_SELECT_B[u]),
        .a_par(a_in),
        .b_par(b_in),
        .a_chain(a_ch),
        .b_chain(b_ch),
        .sign_a(sa),
        .sign_b(sb),
        .nine(nine_sel[u/2]),
        .rnd(pair_rnd[u/2] & ~wide),
        .sat(pair_sat[u/2] & ~wide),
        .a_ff(a_reg[u*18 +: 18]),
        .b_ff(b_reg[u*18 +: 18]),
        .prod(prod[u*36 +: 36])
      );
    end
  endgenerate

  assign SHIFT_OUT_A = a_reg[71:54];
  assign SHIFT_OUT_B = b_reg[71:54];

  // ****************************************
  // 36x36 recombination, no adder stage after it
  // ****************************************
  wire e1 = SIGN_A; // high a times low b
  wire e2 = SIGN_B; // low a times high b
  wire [71:0] wide_prod = {prod[143:108], 36'h000000000}
                        + {{18{e1 & prod[71]}}, prod[71:36], 18'h00000}
                        + {{18{e2 & prod[107]}}, prod[107:72], 18'h00000}
                        + {36'h000000000, prod[35:0]};

  // ****************************************
  // per-half adders and accumulators
  // ****************************************
  wire [105:0] s2_all; // two-product sums per half
  wire [143:0] half_word;
  // summation stage joins both halves' pair sums for 18x18
  wire [52:0] f18 = s2_all[52:0] + s2_all[105:53];

  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_half
      wire [35:0] pa = prod[(2*h)*36 +: 36];
      wire [35:0] pb = prod[(2*h+1)*36 +: 36];
      wire sub = ~add_sel[h]; // high selects add
      wire nine = nine_sel[h];
      wire [1:0] mode = mode_sel[2*h +: 2];
      wire en = STAGE_CLOCK_ENABLE[2*h+1];
      wire signed [52:0] pax = {{17{ext & pa[35]}}, pa};
      wire signed [52:0] pbx = {{17{ext & pb[35]}}, pb};
      wire signed [52:0] s2_raw = sub ? pax - pbx : pax + pbx;
      wire [52:0] s2 = ACCUM_ROUND[h] ? ((s2_raw + `MAB_SUM_RND_INC) & ~`MAB_SUM_RND_MASK)
                                      : s2_raw;
      // 9x9 pairs are the high and low products of each unit
      wire signed [19:0] q0 = {{2{ext & pa[17]}}, pa[17:0]};
      wire signed [19:0] q1 = {{2{ext & pa[35]}}, pa[35:18]};
      wire signed [19:0] q2 = {{2{ext & pb[17]}}, pb[17:0]};
      wire signed [19:0] q3 = {{2{ext & pb[35]}}, pb[35:18]};
      wire signed [19:0] ta = sub ? q0 - q1 : q0 + q1;
      wire signed [19:0] tb = sub ? q2 - q3 : q2 + q3;
      wire signed [19:0] f9 = ta + tb;
      assign s2_all[h*53 +: 53] = s2;

      // accumulator: load replaces, else add or subtract the unit product
      reg [51:0] acc_ff; // 52-bit accumulator of this half
      wire [52:0] acc_x = {acc_ff[51], acc_ff};
      wire [52:0] acc_sum = sub ? acc_x - pax : acc_x + pax;
      wire [52:0] acc_r = ACCUM_ROUND[h] ? ((acc_sum + `MAB_SUM_RND_INC) & ~`MAB_SUM_RND_MASK)
                                         : acc_sum;
      wire ovf = acc_r[52] ^ acc_r[51];
      wire mac = (mode == `MAB_MODE_ACCUM) & ~nine & ~wide;
      reg [51:0] nxt_acc;

      // saturation clamps on overflow instead of wrapping
      always @* begin
        if (ACCUM_LOAD[h]) begin
          nxt_acc = pax[51:0];
        end else if (ACCUM_SATURATE[h] && ovf) begin
          nxt_acc = acc_r[52] ? `MAB_ACC_MIN : `MAB_ACC_MAX;
        end else begin
          nxt_acc = acc_r[51:0];
        end
      end

      assign sat_set[h] = mac & en & ~ACCUM_LOAD[h] & ACCUM_SATURATE[h] & ovf;

      // accumulator runs on the half's output clear/enable set
      always @(posedge REF_CLK or posedge clr_set[2*h+1]) begin
        if (clr_set[2*h+1]) begin
          acc_ff <= 52'h0000000000000;
        end else if (en && mac) begin
          acc_ff <= nxt_acc;
        end
      end

      reg [71:0] hw;

      // result selection per half; 36x36 and the 18x18 four-product sum put the whole result in half 0
      always @* begin
        hw = {pb, pa};
        if (wide) begin
          hw = (h == 0) ? wide_prod : 72'h0;
        end else begin
          case (mode)
            `MAB_MODE_ACCUM: begin
              // 9x9 has no accumulator; it stays a plain multiplier
              if (!nine) begin
                hw = {{20{acc_ff[51]}}, acc_ff};
              end
            end
            `MAB_MODE_ADD2: begin
              if (nine) begin
                hw = {{16{tb[19]}}, tb, {16{ta[19]}}, ta};
              end else begin
                hw = {{19{s2[52]}}, s2};
              end
            end
            `MAB_MODE_ADD4: begin
              if (nine) begin
                hw = {{52{f9[19]}}, f9};
              end else begin
                hw = (h == 0) ? {{19{f18[52]}}, f18} : 72'h0;
              end
            end
            default: begin
              hw = {pb, pa};
            end
          endcase
        end
      end

      assign half_word[h*72 +: 72] = hw;
    end
  endgenerate

  // ****************************************
  // output register stage
  // ****************************************
  // the pins are always driven from a flop; with the stage bypassed it
  // follows every cycle and ignores enable, keeping one cycle of latency
  genvar o;
  generate
    for (o = 0; o < 2; o = o + 1) begin : g_out
      reg [71:0] res_ff; // one flop bank per half, each on its own clear
      always @(posedge REF_CLK or posedge clr_set[2*o+1]) begin
        if (clr_set[2*o+1]) begin
          res_ff <= 72'h0;
        end else if (STAGE_CLOCK_ENABLE[2*o+1] || !out_on) begin
          res_ff <= half_word[o*72 +: 72];
        end
      end
      assign RESULT[o*72 +: 72] = res_ff;
    end
  endgenerate

endmodule // mab_top

//--- bench/mab_top_asserts.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module mab_chk (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // control bus
  input wire [3:0] ASYNC_CLEAR,
  input wire [3:0] STAGE_CLOCK_ENABLE,
  input wire SIGN_A,
  input wire SIGN_B,
  input wire PAIR_LOW_PRODUCT_SATURATE,
  input wire PAIR_LOW_PRODUCT_ROUND,
  input wire [1:0] LOW_HALF_MODE_SELECT,
  input wire [1:0] HIGH_HALF_MODE_SELECT,
  input wire [3:0] SHIFT_SELECT_A,
  input wire [3:0] SHIFT_SELECT_B,
  // data
  input wire [71:0] OPERAND_A,
  input wire [71:0] OPERAND_B,
  input wire [143:0] RESULT,
  input wire [17:0] SHIFT_OUT_A,
  input wire [17:0] SHIFT_OUT_B,
  // register bus
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire AVS_WAITREQUEST
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // accepted write; a config change mid-flight voids the latency checks
  wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  // shadow of the control register, kept from observed writes
  reg [5:0] ctrl_ff;
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) ctrl_ff <= 6'h07;
    else if (wr_ok && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0]) ctrl_ff <= AVS_WRITEDATA[5:0];
  end
  // reference products of unit 0 (18x18) and unit 2 low (9x9)
  wire [35:0] p0 = OPERAND_A[17:0] * OPERAND_B[17:0];
  wire [17:0] q2 = OPERAND_A[44:36] * OPERAND_B[44:36];
  wire plain = !SIGN_A && !SIGN_B && !wr_ok;
  wire lo_ok = plain && ctrl_ff == 6'h07 && LOW_HALF_MODE_SELECT == 2'h0
    && !PAIR_LOW_PRODUCT_ROUND && !PAIR_LOW_PRODUCT_SATURATE && !SHIFT_SELECT_A[0]
    && !SHIFT_SELECT_B[0] && STAGE_CLOCK_ENABLE[1:0] == 2'h3 && ASYNC_CLEAR[1:0] == 2'h0;
  wire hi_ok = plain && ctrl_ff == 6'h27 && HIGH_HALF_MODE_SELECT == 2'h0
    && !SHIFT_SELECT_A[2] && !SHIFT_SELECT_B[2]
    && STAGE_CLOCK_ENABLE[3:2] == 2'h3 && ASYNC_CLEAR[3:2] == 2'h0;
  // ****
  // assertions
  // ****
  bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  wait_cause_a: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("answer without request");
  low_clear_a: assert property (ASYNC_CLEAR[1] |-> RESULT[71:0] == 72'h0)
    else $error("low half not cleared");
  high_clear_a: assert property (ASYNC_CLEAR[3] |-> RESULT[143:72] == 72'h0
    && SHIFT_OUT_A == 18'h0 && SHIFT_OUT_B == 18'h0)
    else $error("high half not cleared");
  low_hold_a: assert property (ctrl_ff[2] && !STAGE_CLOCK_ENABLE[1] && !wr_ok |=> $stable(RESULT[71:0]) || ASYNC_CLEAR[1])
    else $error("result moved while disabled");
  low_product_a: assert property (lo_ok [*3] |=> RESULT[35:0] == $past(p0, 3) || ASYNC_CLEAR[1])
    else $error("unit product wrong");
  nine_product_a: assert property (hi_ok [*3] |=> RESULT[89:72] == $past(q2, 3) || ASYNC_CLEAR[3])
    else $error("small product wrong");
  // in 36x36 mode unit 3 loads the upper word of operand a, not its own bus
  chain_out_a: assert property (ctrl_ff[0] && !ctrl_ff[3] && STAGE_CLOCK_ENABLE[3]
    && !SHIFT_SELECT_A[3] && !ASYNC_CLEAR[3] && !wr_ok
    |=> SHIFT_OUT_A == $past(OPERAND_A[71:54]) || ASYNC_CLEAR[3])
    else $error("chain output wrong");
  // main scenarios reached
  cover property (lo_ok [*3]);
  cover property (hi_ok [*3]);
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property (LOW_HALF_MODE_SELECT == 2'h1 && STAGE_CLOCK_ENABLE[1]);
endmodule // mab_chk

bind mab_top mab_chk mab_chk_inst (.*);

//--- bench/mab_chain_src.sv
`timescale 1ns/1ps
// ****
// upstream block in the column: its last input stage feeds our chain
// ****
module mab_chain_src (
  // clock and clear
  input wire clk,
  input wire clr,
  // operands loaded upstream
  input wire ena,
  input wire [17:0] din_a,
  input wire [17:0] din_b,
  // chain toward the block under test
  output reg [17:0] sh_a_ff,
  output reg [17:0] sh_b_ff
);
  // a real flop, so our unit 0 sees the value one edge late
  always @(posedge clk or posedge clr) begin
    if (clr) begin
      sh_a_ff <= 18'h0;
      sh_b_ff <= 18'h0;
    end else if (ena) begin
      sh_a_ff <= din_a;
      sh_b_ff <= din_b;
    end
  end
endmodule // mab_chain_src

//--- bench/tb_mab_top.sv
`timescale 1ns/1ps
module tb_mab_top;
  // one row: operands, sign, round, saturate, expected unit product
  typedef struct packed {
    logic [17:0] a;
    logic [17:0] b;
    logic sg;
    logic rnd;
    logic sat;
    logic [35:0] p;
  } mab_row_t;
  mab_row_t rows [8] = '{
    '{18'h00003, 18'h00005, 1'b0, 1'b0, 1'b0, 36'h00000000f},
    '{18'h3ffff, 18'h3ffff, 1'b0, 1'b0, 1'b0, 36'hffff80001},
    '{18'h3ffff, 18'h00002, 1'b1, 1'b0, 1'b0, 36'hffffffffe},
    '{18'h20000, 18'h20000, 1'b1, 1'b0, 1'b0, 36'h400000000},
    '{18'h00001, 18'h06000, 1'b1, 1'b1, 1'b0, 36'h000008000},
    '{18'h3ffff, 18'h00001, 1'b1, 1'b1, 1'b0, 36'h000000000},
    '{18'h20000, 18'h20000, 1'b1, 1'b0, 1'b1, 36'h03fffffff},
    '{18'h20000, 18'h1ffff, 1'b1, 1'b0, 1'b1, 36'hfc0000000}};
  logic ref_clk, rst, sign_a, sign_b, lo_sat, lo_rnd, hi_sat, hi_rnd, lo_add, hi_add;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] clr_set, en_set, sel_a, sel_b, avs_address, avs_byteenable;
  logic [1:0] lo_mode, hi_mode, acc_rnd, acc_sat, acc_load;
  logic [71:0] opa, opb;
  logic [143:0] result, r1;
  logic [17:0] sh_in_a, sh_in_b, sh_out_a, sh_out_b, din_a;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_fail, checks_done;

  mab_top mab_top_inst (.REF_CLK(ref_clk), .RST(rst), .ASYNC_CLEAR(clr_set),
    .STAGE_CLOCK_ENABLE(en_set), .SIGN_A(sign_a), .SIGN_B(sign_b),
    .PAIR_LOW_PRODUCT_SATURATE(lo_sat), .PAIR_LOW_PRODUCT_ROUND(lo_rnd),
    .PAIR_HIGH_PRODUCT_SATURATE(hi_sat), .PAIR_HIGH_PRODUCT_ROUND(hi_rnd),
    .LOW_HALF_ADD_SUBTRACT_SELECT(lo_add), .HIGH_HALF_ADD_SUBTRACT_SELECT(hi_add),
    .LOW_HALF_MODE_SELECT(lo_mode), .HIGH_HALF_MODE_SELECT(hi_mode), .ACCUM_ROUND(acc_rnd),
    .ACCUM_SATURATE(acc_sat), .ACCUM_LOAD(acc_load), .SHIFT_SELECT_A(sel_a),
    .SHIFT_SELECT_B(sel_b), .OPERAND_A(opa), .OPERAND_B(opb), .RESULT(result),
    .SHIFT_IN_A(sh_in_a), .SHIFT_IN_B(sh_in_b), .SHIFT_OUT_A(sh_out_a),
    .SHIFT_OUT_B(sh_out_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));
  mab_chain_src mab_chain_src_inst (.clk(ref_clk), .clr(rst), .ena(1'b1), .din_a(din_a),
    .din_b(~din_a), .sh_a_ff(sh_in_a), .sh_b_ff(sh_in_b));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // ****
  // shared tasks
  // ****
  task end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [143:0] e, input logic [143:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // let n edges pass, then sample once the updates have landed
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one bus access; the request is held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
    input logic [3:0] be, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      end_of_test;
    end
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    // control bus comes from the user logic side
    {ref_clk, sign_a, sign_b, lo_sat, lo_rnd, hi_sat, hi_rnd, avs_read, avs_write} = 9'h0;
    {clr_set, sel_a, sel_b, lo_mode, hi_mode, acc_rnd, acc_sat, acc_load} = 22'h0;
    {opa, opb, din_a, avs_address, avs_byteenable, avs_writedata} = 202'h0;
    {lo_add, hi_add, en_set, rst} = 7'h3f;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    step(1);
    chk("reset result", 144'h0, result);
    chk("reset wait", 1'b1, avs_waitrequest);
    bus(1'b0, 4'h0, 32'h0, 4'hf, rd);
    chk("ctrl reset", 32'h7, rd);
    bus(1'b0, 4'h4, 32'h0, 4'hf, rd);
    chk("status reset", 32'h0, rd);
    // ordinary products, same operands on all four units
    foreach (rows[i]) begin
      @(posedge ref_clk);
      opa <= {4{rows[i].a}};
      opb <= {4{rows[i].b}};
      sign_a <= rows[i].sg;
      sign_b <= rows[i].sg;
      {lo_rnd, hi_rnd} <= {2{rows[i].rnd}};
      {lo_sat, hi_sat} <= {2{rows[i].sat}};
      step(3);
      chk("products", {4{rows[i].p}}, result);
    end
    // high half split into 9x9 while low half stays 18x18
    bus(1'b1, 4'h0, 32'h27, 4'hf, rd);
    @(posedge ref_clk);
    {sign_a, sign_b, lo_rnd, hi_rnd, lo_sat, hi_sat} <= 6'h0;
    opa <= {18'h0, 9'd3, 9'd4, 18'h0, 18'd7};
    opb <= {18'h0, 9'd5, 9'd6, 18'h0, 18'd9};
    step(3);
    chk("nine", {18'd15, 18'd24}, result[107:72]);
    chk("mixed", 36'd63, result[35:0]);
    @(posedge ref_clk);
    hi_mode <= 2'h2;
    step(3);
    chk("nine pair", 72'd39, result[143:72]);
    // two-product difference then sum
    bus(1'b1, 4'h0, 32'h07, 4'hf, rd);
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      lo_mode <= 2'h2;
      lo_add <= s[0];
      opa <= {18'd1, 18'd1, 18'd2, 18'd5};
      opb <= {18'd1, 18'd1, 18'd3, 18'd7};
      step(3);
      chk("pair sum", s ? 72'd41 : 72'd29, result[71:0]);
    end
    @(posedge ref_clk);
    lo_mode <= 2'h3;
    hi_mode <= 2'h3;
    step(3);
    chk("quad sum", 144'd43, result);
    // accumulate: load, then grow by one product per edge
    @(posedge ref_clk);
    {lo_mode, hi_mode, acc_load} <= 6'h11;
    opa <= 72'd2;
    opb <= 72'd3;
    step(5);
    chk("acc load", 72'd6, result[71:0]);
    @(posedge ref_clk);
    acc_load <= 2'h0;
    step(5);
    chk("acc step", 72'd30, result[71:0]);
    @(posedge ref_clk);
    en_set <= 4'hd;
    step(1);
    r1 = result;
    step(3);
    chk("hold", r1, result);
    @(posedge ref_clk);
    clr_set <= 4'ha;
    step(1);
    chk("clear", 144'h0, result);
    chk("chain clear", 36'h0, {sh_out_b, sh_out_a});
    @(posedge ref_clk);
    clr_set <= 4'h0;
    en_set <= 4'hf;
    // 36x36, accumulate mode selected but not honoured
    bus(1'b1, 4'h0, 32'h0f, 4'hf, rd);
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      sign_a <= !s[0];
      opa <= {36'h0, 36'hfffffffff};
      opb <= {36'h0, 36'd3};
      step(3);
      chk("wide", s ? 144'h2ffffffffd : {72'h0, 72'hfffffffffffffffffd}, result);
    end
    chk("wide no acc", 72'h0, result[143:72]);
    // all stages bypassed: only the output flop remains
    bus(1'b1, 4'h0, 32'h00, 4'hf, rd);
    @(posedge ref_clk);
    {sign_a, lo_mode} <= 3'h0;
    opa <= 72'd11;
    opb <= 72'd13;
    step(1);
    chk("bypass", 36'd143, result[35:0]);
    // shift chain through all four units
    bus(1'b1, 4'h0, 32'h07, 4'hf, rd);
    @(posedge ref_clk);
    {sel_a, sel_b} <= 8'hff;
    din_a <= 18'h2a5a5;
    step(6);
    chk("chain", {~18'h2a5a5, 18'h2a5a5}, {sh_out_b, sh_out_a});
    // refused accesses
    bus(1'b1, 4'h0, 32'h00, 4'h0, rd);
    bus(1'b0, 4'h0, 32'h0, 4'hf, rd);
    chk("ctrl kept", 32'h7, rd);
    bus(1'b1, 4'hc, 32'h3f, 4'hf, rd);
    bus(1'b0, 4'hc, 32'h0, 4'hf, rd);
    chk("unmapped", 32'h0, rd);
    end_of_test;
  end
endmodule // tb_mab_top
